// file: verilog/ctx_defs.vh
// Constants for the test, exclusive-OR and trap execution block
`ifndef CTX_DEFS_VH
`define CTX_DEFS_VH
// AXI4-Lite register byte offsets
`define CTX_REG_STATUS 8'h00
`define CTX_REG_CMD 8'h04
`define CTX_REG_OPS 8'h08
`define CTX_REG_EXT 8'h0c
`define CTX_REG_SPPC 8'h10
`define CTX_REG_STK 8'h14
`define CTX_REG_INFO 8'h18
// Flag bit positions
`define CTX_F_C 7
`define CTX_F_Z 6
`define CTX_F_S 5
`define CTX_F_V 4
`define CTX_F_D 3
`define CTX_F_H 2
`define CTX_F_U2 1
`define CTX_F_U1 0
// Arithmetic flags reset value; user bits keep their value
`define CTX_FLAGS_RST 6'h00
// Opcodes
`define CTX_OP_TM_LO 8'h72
`define CTX_OP_TM_HI 8'h77
`define CTX_OP_TMX_ER 8'h78
`define CTX_OP_TMX_IM 8'h79
`define CTX_OP_XOR_LO 8'hb2
`define CTX_OP_XOR_HI 8'hb7
`define CTX_OP_EXCLUSIVE_OR_EXT_ER 8'hb8
`define CTX_OP_EXCLUSIVE_OR_EXT_IM 8'hb9
`define CTX_OP_TRAP 8'hf2
`define CTX_OP_WDT 8'h5f
// Cycle counts
`define CTX_FETCH_EXT 4'h4
`define CTX_EXEC_EXT 4'h3
`define CTX_FETCH_REG 4'h2
`define CTX_FETCH_REG3 4'h3
`define CTX_EXEC_REG 4'h3
`define CTX_EXEC_REG4 4'h4
`define CTX_FETCH_TRAP 4'h2
`define CTX_EXEC_TRAP 4'h6
`define CTX_FETCH_WDT 4'h1
`define CTX_EXEC_WDT 4'h2
// Unmapped read value
`define CTX_BAD_READ 32'h00000000
`endif

// file: verilog/ctx_alu.v
// Logic unit: AND or XOR of two bytes with zero and sign results
`default_nettype none
module ctx_alu (
  // Operands
  input wire [7:0] dst_i,
  input wire [7:0] src_i,
  input wire use_xor_i,
  // Results
  output wire [7:0] res_o,
  output wire zero_o,
  output wire sign_o
);
  assign res_o = use_xor_i ? (dst_i ^ src_i) : (dst_i & src_i);
  assign zero_o = (res_o == 8'h00);
  assign sign_o = res_o[7];
endmodule // ctx_alu
`default_nettype wire

// file: verilog/ctx_top.v
// Test-AND, exclusive-OR, trap and flags execution block with AXI4-Lite access
// Overview of operation
// - Opcodes 72 to 77 AND the operands, drop the result, set zero and sign, clear overflow.
// - Opcodes 78 and 79 AND extended operands without write, set Z and S, clear V, 4+3 cycles.
// - Opcode F2 pushes the PC at SP-2, the flags at SP-3, then loads the PC from the vector.
// - Opcodes B2 to B7 write dst XOR src back, set zero and sign, clear overflow, keep carry.
// - Opcodes B8 and B9 store the XOR in the extended target with Z, S, V=0 and 4+3 cycles.
// - The flags show the status of the last logic operation done, or the value of a later status write or interrupt return.
// - Carry, overflow, zero and sign are offered to conditional jumps.
// - Half-carry and decimal bits serve BCD only and are not offered to jumps.
// - User bits change only by status writes and interrupt return, and are not offered to jumps.
// - User bits are not initialised and reset leaves them alone.
// - Interrupts, software traps and illegal-opcode traps push the flags onto the stack.
// - Interrupt return reloads the flags from the saved stack value.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
`include "ctx_defs.vh"
module ctx_top (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Core side
  output reg [3:0] jump_flags_o,
  output reg watchdog_restart_o,
  output reg busy_o
);
  // ********************************************************
  // Reset synchroniser
  // ********************************************************
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // ********************************************************
  // Registers
  // ********************************************************
  reg [5:0] arith_q;   // C Z S V D H
  reg [1:0] user_q;    // U2 U1, no reset
  reg [7:0] opcode_q;
  reg [7:0] dst_q;
  reg [7:0] src_q;
  reg [7:0] ext_q;
  reg [7:0] vector_q;
  reg [15:0] sp_q;
  reg [15:0] pc_q;
  reg [15:0] stk_pc_q;
  reg [7:0] stk_flags_q;
  reg [3:0] fetch_q;
  reg [3:0] exec_q;
  reg [3:0] cnt_q;
  reg ill_q;
  wire [7:0] flags = {arith_q, user_q};

  // ********************************************************
  // Logic unit
  // ********************************************************
  wire is_tm = (opcode_q >= `CTX_OP_TM_LO) && (opcode_q <= `CTX_OP_TM_HI);
  wire is_tmx = (opcode_q == `CTX_OP_TMX_ER) || (opcode_q == `CTX_OP_TMX_IM);
  wire is_xor = (opcode_q >= `CTX_OP_XOR_LO) && (opcode_q <= `CTX_OP_XOR_HI);
  wire is_exclusive_or_ext = (opcode_q == `CTX_OP_EXCLUSIVE_OR_EXT_ER) || (opcode_q == `CTX_OP_EXCLUSIVE_OR_EXT_IM);
  wire is_trap = (opcode_q == `CTX_OP_TRAP);
  wire is_wdt = (opcode_q == `CTX_OP_WDT);
  wire [7:0] alu_res;
  wire alu_z;
  wire alu_s;
  ctx_alu u_alu (
    .dst_i(is_exclusive_or_ext || is_tmx ? ext_q : dst_q),
    .src_i(src_q),
    .use_xor_i(is_xor || is_exclusive_or_ext),
    .res_o(alu_res),
    .zero_o(alu_z),
    .sign_o(alu_s)
  );

  // ********************************************************
  // AXI4-Lite slave
  // ********************************************************
  reg [7:0] aw_q;
  reg aw_have_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  reg w_have_q;
  wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid_o;
  wire [7:0] cmd_byte = w_q[7:0];
  wire wr_cmd = wr_go && (aw_q == `CTX_REG_CMD) && ws_q[0];
  wire wr_status = wr_go && (aw_q == `CTX_REG_STATUS) && ws_q[0];
  wire wr_ok = (aw_q == `CTX_REG_STATUS) || (aw_q == `CTX_REG_CMD) ||
               (aw_q == `CTX_REG_OPS) || (aw_q == `CTX_REG_EXT) ||
               (aw_q == `CTX_REG_SPPC);
  // Command bit 8: opcode start; bits 9,10,11: interrupt, illegal trap, return
  wire start = wr_cmd && w_q[8] && !busy_o;
  wire take_irq = wr_go && (aw_q == `CTX_REG_CMD) && ws_q[1] && w_q[9] && !busy_o;
  wire take_ill = wr_go && (aw_q == `CTX_REG_CMD) && ws_q[1] && w_q[10] && !busy_o;
  wire do_interrupt_return_op = wr_go && (aw_q == `CTX_REG_CMD) && ws_q[1] && w_q[11] && !busy_o;

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      s_axi_awready_o <= !aw_have_q && !s_axi_awready_o;
      s_axi_wready_o <= !w_have_q && !s_axi_wready_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata_i;
        ws_q <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= 2'h0;
      s_axi_rdata_o <= 32'h00000000;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= 2'h0;
        case (s_axi_araddr_i)
          `CTX_REG_STATUS: s_axi_rdata_o <= {23'h000000, busy_o, flags};
          `CTX_REG_CMD: s_axi_rdata_o <= {24'h000000, opcode_q};
          `CTX_REG_OPS: s_axi_rdata_o <= {8'h00, vector_q, src_q, dst_q};
          `CTX_REG_EXT: s_axi_rdata_o <= {24'h000000, ext_q};
          `CTX_REG_SPPC: s_axi_rdata_o <= {sp_q, pc_q};
          `CTX_REG_STK: s_axi_rdata_o <= {8'h00, stk_flags_q, stk_pc_q};
          `CTX_REG_INFO: s_axi_rdata_o <= {20'h00000, fetch_q, exec_q, 3'h0, ill_q};
          default: begin
            s_axi_rdata_o <= `CTX_BAD_READ;
            s_axi_rresp_o <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Execution sequencer
  // ********************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  reg [1:0] state_q;
  wire exec_done = (state_q == ST_EXEC) && (cnt_q == 4'h1);

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      busy_o <= 1'b0;
      fetch_q <= 4'h0;
      exec_q <= 4'h0;
      ill_q <= 1'b0;
      watchdog_restart_o <= 1'b0;
    end else begin
      watchdog_restart_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_EXEC;
            busy_o <= 1'b1;
            ill_q <= 1'b0;
            if ((cmd_byte == `CTX_OP_TMX_ER) || (cmd_byte == `CTX_OP_TMX_IM) ||
                (cmd_byte == `CTX_OP_EXCLUSIVE_OR_EXT_ER) || (cmd_byte == `CTX_OP_EXCLUSIVE_OR_EXT_IM)) begin
              fetch_q <= `CTX_FETCH_EXT;
              exec_q <= `CTX_EXEC_EXT;
            end else if (cmd_byte == `CTX_OP_TRAP) begin
              fetch_q <= `CTX_FETCH_TRAP;
              exec_q <= `CTX_EXEC_TRAP;
            end else if (cmd_byte == `CTX_OP_WDT) begin
              fetch_q <= `CTX_FETCH_WDT;
              exec_q <= `CTX_EXEC_WDT;
            end else begin
              fetch_q <= (cmd_byte[2:0] < 3'h4) ? `CTX_FETCH_REG : `CTX_FETCH_REG3;
              exec_q <= cmd_byte[0] ? `CTX_EXEC_REG4 : `CTX_EXEC_REG;
            end
            cnt_q <= 4'h1;
          end
        end
        ST_EXEC: begin
          if (cnt_q == 4'h1) begin
            state_q <= ST_IDLE;
            busy_o <= 1'b0;
            if (!(is_tm || is_tmx || is_xor || is_exclusive_or_ext || is_trap || is_wdt)) begin
              ill_q <= 1'b1;
            end
            if (is_wdt) begin
              watchdog_restart_o <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Operands, flags, stack and program counter
  // ********************************************************
  wire trap_push = exec_done && is_trap;
  wire any_push = trap_push || take_irq || take_ill;
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      arith_q <= `CTX_FLAGS_RST;
      opcode_q <= 8'h00;
      dst_q <= 8'h00;
      src_q <= 8'h00;
      ext_q <= 8'h00;
      vector_q <= 8'h00;
      sp_q <= 16'h0000;
      pc_q <= 16'h0000;
      stk_pc_q <= 16'h0000;
      stk_flags_q <= 8'h00;
      jump_flags_o <= 4'h0;
    end else begin
      jump_flags_o <= {arith_q[5], arith_q[2], arith_q[4], arith_q[3]};
      if (start) begin
        opcode_q <= cmd_byte;
      end
      if (wr_go && (aw_q == `CTX_REG_OPS)) begin
        if (ws_q[0]) dst_q <= w_q[7:0];
        if (ws_q[1]) src_q <= w_q[15:8];
        if (ws_q[2]) vector_q <= w_q[23:16];
      end
      if (wr_go && (aw_q == `CTX_REG_EXT) && ws_q[0]) begin
        ext_q <= w_q[7:0];
      end
      if (wr_go && (aw_q == `CTX_REG_SPPC)) begin
        if (ws_q[0]) pc_q[7:0] <= w_q[7:0];
        if (ws_q[1]) pc_q[15:8] <= w_q[15:8];
        if (ws_q[2]) sp_q[7:0] <= w_q[23:16];
        if (ws_q[3]) sp_q[15:8] <= w_q[31:24];
      end
      if (wr_status) begin
        arith_q <= w_q[7:2];
      end
      if (exec_done && (is_tm || is_tmx || is_xor || is_exclusive_or_ext)) begin
        arith_q[4] <= alu_z;
        arith_q[3] <= alu_s;
        arith_q[2] <= 1'b0;
      end
      if (exec_done && is_xor) begin
        dst_q <= alu_res;
      end
      if (exec_done && is_exclusive_or_ext) begin
        ext_q <= alu_res;
      end
      if (any_push) begin
        sp_q <= sp_q - 16'h0003;
        stk_pc_q <= pc_q;
        stk_flags_q <= flags;
        pc_q <= {8'h00, vector_q};
      end else if (do_interrupt_return_op) begin
        arith_q <= stk_flags_q[7:2];
        pc_q <= stk_pc_q;
        sp_q <= sp_q + 16'h0003;
      end
    end
  end

  // User bits have no reset at all
  always @(posedge clock_i) begin
    if (wr_status) begin
      user_q <= w_q[1:0];
    end else if (do_interrupt_return_op) begin
      user_q <= stk_flags_q[1:0];
    end
  end
endmodule // ctx_top
`default_nettype wire

// file: tb/ctx_top_asserts.sv
// Concurrent checks on the ports of the test, exclusive-OR and trap block
`default_nettype none
module ctx_top_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Bus handshakes
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  // Core side
  input wire logic [3:0] jump_flags_o,
  input wire logic watchdog_restart_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  a_wdt_single: assert property (watchdog_restart_o |=> !watchdog_restart_o)
    else $error("watchdog restart longer than one cycle");
  a_wdt_from_exec: assert property (watchdog_restart_o |-> $past(busy_o) || $past(busy_o, 2))
    else $error("watchdog restart without an executed opcode");
  a_wdt_keeps_flags: assert property (watchdog_restart_o |=> $stable(jump_flags_o) [*2])
    else $error("watchdog refresh changed the flags");
  a_flags_have_cause: assert property ($changed(jump_flags_o) |->
    $past(busy_o) || $past(busy_o, 2) || s_axi_bvalid_o || $past(s_axi_bvalid_o))
    else $error("flags changed with no operation or write");
  a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before taken");
  a_rresp_code: assert property (s_axi_rvalid_o |-> s_axi_rresp_o inside {2'h0, 2'h2})
    else $error("read response code not okay or slave error");
  a_busy_brief: assert property ($rose(busy_o) |=> ##[0:7] !busy_o)
    else $error("execution did not finish");
endmodule // ctx_top_asserts
bind ctx_top ctx_top_asserts chk_u (.clock_i, .rst_n_i, .s_axi_bready_i, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
  .jump_flags_o, .watchdog_restart_o, .busy_o);
`default_nettype wire

// file: tb/ctx_core_model.sv
// Core-side model: jump condition unit and watchdog restart counter
`default_nettype none
module ctx_core_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Core side
  input wire logic [3:0] jump_flags_i,
  input wire logic watchdog_restart_i,
  // Observations
  output logic [7:0] restarts_o,
  output logic [7:0] cond_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Jumps see only C, V, Z and S, each on set or clear
  assign cond_o = {~jump_flags_i, jump_flags_i};
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restarts_o <= 8'h00;
    end else if (watchdog_restart_i) begin
      restarts_o <= restarts_o + 8'h01;
    end
  end
endmodule // ctx_core_model
`default_nettype wire

// file: tb/test_ctx_top.sv
// Self-checking bench for the test, exclusive-OR, trap and flags block
`default_nettype none
`include "ctx_defs.vh"
module test_ctx_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, rst_n_i = 0;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, restarts, cond;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, jump_flags_o;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic watchdog_restart_o, busy_o;
  int seed = 85, miscompares = 0, checks = 0, cycles = 0;
  ctx_top dut_u (.clock_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .jump_flags_o,
    .watchdog_restart_o, .busy_o);
  ctx_core_model mdl_u (.clock_i, .rst_n_i, .jump_flags_i(jump_flags_o),
    .watchdog_restart_i(watchdog_restart_o), .restarts_o(restarts), .cond_o(cond));
  always #5 clock_i = ~clock_i;
  task automatic stop_test;
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    while (!(aw && w)) begin
      @(posedge clock_i);
      if (s_axi_awready_o && !aw) begin
        aw = 1;
        s_axi_awvalid_i <= 0;
      end
      if (s_axi_wready_o && !w) begin
        w = 1;
        s_axi_wvalid_i <= 0;
      end
    end
    repeat ($random(seed) & 3) @(posedge clock_i);
    s_axi_bready_i <= 1;
    do @(posedge clock_i); while (!s_axi_bvalid_o);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do @(posedge clock_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 0;
    repeat ($random(seed) & 3) @(posedge clock_i);
    s_axi_rready_i <= 1;
    do @(posedge clock_i); while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 0;
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, 0);
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
    chk(r, 0);
  endtask
  // Command write, then wait for execution and the one-cycle lag of the jump flags
  task automatic run(input logic [11:0] c);
    put(`CTX_REG_CMD, {20'h0, c});
    do @(posedge clock_i); while (busy_o);
    repeat (2) @(posedge clock_i);
  endtask
  // Z and S from the result, V cleared, all other bits kept
  function automatic logic [7:0] exp_f(input logic [7:0] op, f, d, s, e);
    logic [7:0] r;
    r = op[7] ? (op[3] ? e : d) ^ s : (op[3] ? e : d) & s;
    exp_f = f;
    exp_f[6] = (r == 8'h00);
    exp_f[5] = r[7];
    exp_f[4] = 1'b0;
  endfunction
  initial begin
    logic [7:0] op, f, d, s, e, v, x;
    logic [15:0] pc;
    logic [31:0] q;
    logic [1:0] r;
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1;
    repeat (6) @(posedge clock_i);
    for (int i = 0; i < 48; i++) begin
      op = (i[3] ? 8'hb2 : 8'h72) + 8'(i % 8);
      {f, d, s, e} = $random(seed);
      if (i < 16) d = 8'h00;
      put(`CTX_REG_STATUS, {24'h0, f});
      put(`CTX_REG_OPS, {16'h0, s, d});
      put(`CTX_REG_EXT, {24'h0, e});
      run({4'h1, op});
      x = exp_f(op, f, d, s, e);
      get(`CTX_REG_STATUS, q);
      chk(q[7:0], x);
      chk(cond, {~x[7], ~x[4], ~x[6], ~x[5], x[7], x[4], x[6], x[5]});
      get(`CTX_REG_OPS, q);
      chk(q[7:0], (op[7] && !op[3]) ? d ^ s : d);
      get(`CTX_REG_EXT, q);
      chk(q[7:0], (op[7] && op[3]) ? e ^ s : e);
      if (op[3]) begin
        get(`CTX_REG_INFO, q);
        chk(q[11:8], `CTX_FETCH_EXT);
        chk(q[7:4], `CTX_EXEC_EXT);
      end
    end
    for (int k = 0; k < 3; k++) begin
      {f, v, pc} = $random(seed);
      put(`CTX_REG_STATUS, {24'h0, f});
      put(`CTX_REG_OPS, {8'h0, v, 16'h0});
      put(`CTX_REG_SPPC, {16'h0180, pc});
      run(k == 0 ? 12'h1f2 : 12'h100 << k);
      get(`CTX_REG_SPPC, q);
      chk(q, {16'h017d, 8'h00, v});
      get(`CTX_REG_STK, q);
      chk(q[23:0], {f, pc});
      if (k == 0) begin
        get(`CTX_REG_INFO, q);
        chk(q[11:4], {`CTX_FETCH_TRAP, `CTX_EXEC_TRAP});
      end
      put(`CTX_REG_STATUS, {24'h0, ~f});
      run(12'h800);
      get(`CTX_REG_STATUS, q);
      chk(q[7:0], f);
      get(`CTX_REG_SPPC, q);
      chk(q, {16'h0180, pc});
    end
    x = restarts;
    run(12'h15f);
    chk(restarts, x + 8'h01);
    get(`CTX_REG_STATUS, q);
    chk(q[7:0], f);
    run(12'h100);
    get(`CTX_REG_INFO, q);
    chk(q[0], 1'b1);
    put(`CTX_REG_STATUS, 32'hfe);
    rst_n_i <= 0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1;
    repeat (6) @(posedge clock_i);
    get(`CTX_REG_STATUS, q);
    chk(q[7:0], 8'h02);
    wr(8'h1c, 32'h5a, r);
    chk(r, 2'h2);
    rd(8'h1c, q, r);
    chk(r, 2'h2);
    chk(q, `CTX_BAD_READ);
    stop_test;
  end
endmodule // test_ctx_top
`default_nettype wire
